// ---- include/des_pkg.sv ----
// Constants for the drive enable sequencer: register map, field
// positions, reset values and millisecond timing figures.
// Assumes a 125 MHz system clock; every delay counts 1 ms ticks.
package des_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned DES_CLK_HZ = 125_000_000;
  localparam int unsigned DES_TICK_MS = 1;
  // Cycles per ms tick, derived from rate and tick period
  localparam int unsigned DES_TICK_CYC = DES_CLK_HZ / 1000 * DES_TICK_MS;
  localparam int unsigned DES_SW_MS = 2;
  localparam int unsigned DES_CMD_MS = 5;
  localparam int unsigned DES_GATE_MS = 50;
  localparam int unsigned DES_HW_CUT_MS = 1500;
  localparam int unsigned DES_MS_W = 17;

  ////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] DES_OFS_CTRL = 8'h00;
  localparam logic [7:0] DES_OFS_RAMP = 8'h04;
  localparam logic [7:0] DES_OFS_STATE = 8'h08;
  localparam logic [7:0] DES_OFS_IND = 8'h0C;
  localparam logic [7:0] DES_OFS_ISTAT = 8'h10;
  localparam logic [7:0] DES_OFS_IMASK = 8'h14;

  // Field positions
  localparam int unsigned DES_CTRL_DIS_BIT = 2;
  localparam int unsigned DES_ST_ENA_BIT = 0;
  localparam int unsigned DES_ST_PSTAGE_BIT = 1;
  localparam int unsigned DES_ST_SWCTL_BIT = 2;
  localparam int unsigned DES_ST_CMDOK_BIT = 3;
  localparam int unsigned DES_ST_RAMP_BIT = 4;
  localparam int unsigned DES_ST_PERMIT_BIT = 5;
  localparam int unsigned DES_ST_FSM_LSB = 8;
  localparam int unsigned DES_EV_RISE = 0;
  localparam int unsigned DES_EV_FALL = 1;
  localparam int unsigned DES_EV_GATE = 2;
  localparam int unsigned DES_EV_HWCUT = 3;

  // Reset values
  localparam logic DES_RST_HOST_DIS = 1'b0;
  localparam logic [15:0] DES_RST_RAMP = 16'h0064;
  localparam logic [3:0] DES_RST_IMASK = 4'h0;

  // AXI responses
  localparam logic [1:0] DES_RESP_OKAY = 2'b00;
  localparam logic [1:0] DES_RESP_SLVERR = 2'b10;

  // Sequencer states
  typedef enum logic [2:0] {
    DES_ST_OFF = 3'b000,
    DES_ST_ON = 3'b001,
    DES_ST_STOP_HW = 3'b010,
    DES_ST_STOP_SW = 3'b011,
    DES_ST_HOSTOFF = 3'b100
  } des_state_e;

endpackage : des_pkg

// ---- logic/des_top.sv ----
// Drive enable sequencer: permit hysteresis, enable/disable timing,
// emergency stop ramp, indicators, AXI4-Lite register slave.
// Assumes comparator outputs on pins (asynchronous) and a single
// 125 MHz clock with synchronous active-low reset.
//
// Overview of operation
// [R01] The permit counts as asserted once its input is above 10 V.
// [R02] Below 4 V the permit counts as removed and the drive is disabled.
// [R03] Permit assertion enables the power stage in the very next cycle.
// [R04] Software takes over the power stage 2 ms after permit assertion.
// [R05] Commands are accepted from 5 ms after permit; host must wait.
// [R06] The enable condition is a flag of the state word.
// [R07] Jumper open: permit removal ramps the speed setpoint to zero first.
// [R08] Emergency stop: gate drops 50 ms after standstill or ramp+50 ms.
// [R09] Emergency stop: power stage forced off 1.5 s after removal latest.
// [R10] Jumper closed: permit removal disables the power section at once.
// [R11] Host enable/disable acts only while the permit is asserted.
// [R12] Host clearing bit 2 of the control word enables without delay.
// [R13] Host disable ramps to zero, then gate drops 50 ms after ramp time.
// [R14] Host disable never triggers the 1.5 s hardware cutoff.
// [R15] Input indicator lit above 10 V, output indicator while positive.
// [R16] Indicators for limits, inputs, permit, field, outputs, relay, gate.
// [R17] Delays count 1 ms ticks and restart on each new event.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ns

module des_top
  import des_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = DES_TICK_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparator and sense pins, asynchronous
  input wire logic permit_gt10,
  input wire logic permit_lt4,
  input wire logic [1:0] limit_gt10,
  input wire logic [1:0] din_gt10,
  input wire logic rotating_field_permit,
  input wire logic [3:0] dout_pos,
  input wire logic ready_relay_out,
  input wire logic axis_standstill,
  input wire logic emergency_stop_jumper,
  // Drive control
  output logic power_stage_en,
  output logic gate_go,
  output logic sw_control,
  output logic cmd_accept,
  output logic ramp_to_zero,
  output logic [11:0] ind_led,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (TICK_CYCLES < 2 || TICK_CYCLES > 1_048_576) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  localparam int unsigned NPIN = 14;
  localparam logic [DES_MS_W-1:0] SW_T = DES_MS_W'(DES_SW_MS);
  localparam logic [DES_MS_W-1:0] CMD_T = DES_MS_W'(DES_CMD_MS);
  localparam logic [DES_MS_W-1:0] GATE_T = DES_MS_W'(DES_GATE_MS);
  localparam logic [DES_MS_W-1:0] CUT_T = DES_MS_W'(DES_HW_CUT_MS);
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

  // All state in one record, apart from the assertion helper rd_state_q
  typedef struct packed {
    logic [NPIN-1:0] sy1;
    logic [NPIN-1:0] sy2;
    logic permit;
    des_state_e st;
    logic [19:0] div;
    logic tick;
    logic [DES_MS_W-1:0] en_ms;
    logic [DES_MS_W-1:0] stop_ms;
    logic [DES_MS_W-1:0] still_ms;
    logic host_dis;
    logic [15:0] ramp_ms;
    logic pstage;
    logic gate;
    logic sw_ctl;
    logic cmd_ok;
    logic ramp_req;
    logic [11:0] led;
    logic [3:0] ist;
    logic [3:0] imask;
    logic irq;
    logic awrdy;
    logic wrdy;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } des_regs_s;

  des_regs_s r;
  des_regs_s next_r;

  // Synchronised pin views (second stage only)
  logic s_pgt10, s_plt4, s_rfe, s_rdy, s_still, s_jmp;
  logic [1:0] s_lim, s_din;
  logic [3:0] s_dout;
  assign {s_pgt10, s_plt4, s_lim, s_din, s_rfe, s_dout, s_rdy, s_still,
          s_jmp} = r.sy2;

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic perm_n, rise, fall, wr_go, rd_go, host_wr, stop_hit, gate_hit;
    logic [3:0] ev;
    logic [7:0] ra;
    logic [DES_MS_W-1:0] ramp_end;
    perm_n = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    wr_go = 1'b0;
    rd_go = 1'b0;
    host_wr = 1'b0;
    stop_hit = 1'b0;
    gate_hit = 1'b0;
    ev = 4'h0;
    ra = 8'h00;
    ramp_end = '0;
    next_r = r;

    // Two-stage synchroniser on every pin
    next_r.sy1 = {permit_gt10, permit_lt4, limit_gt10, din_gt10,
                  rotating_field_permit, dout_pos, ready_relay_out,
                  axis_standstill, emergency_stop_jumper};
    next_r.sy2 = r.sy1;

    // Permit hysteresis: set above 10 V, cleared below 4 V
    if (s_pgt10) begin
      perm_n = 1'b1; // R01
    end else if (s_plt4) begin
      perm_n = 1'b0; // R02
    end else begin
      perm_n = r.permit;
    end
    next_r.permit = perm_n;
    rise = perm_n && !r.permit;
    fall = !perm_n && r.permit;

    // Millisecond tick divider
    next_r.tick = 1'b0;
    if (r.div == TICK_LAST) begin
      next_r.div = 20'h0_0000;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + 20'h0_0001;
    end

    // Delay counters, saturating, restarted by events
    if (r.tick && r.en_ms != '1) begin
      next_r.en_ms = r.en_ms + 1'b1; // R17
    end
    if (r.tick && r.stop_ms != '1) begin
      next_r.stop_ms = r.stop_ms + 1'b1; // R17
    end
    if (!s_still) begin
      next_r.still_ms = '0;
    end else if (r.tick && r.still_ms != '1) begin
      next_r.still_ms = r.still_ms + 1'b1;
    end

    // AXI write channel: address and data taken in either order
    next_r.awrdy = !r.aw_have && !r.bvalid;
    next_r.wrdy = !r.w_have && !r.bvalid;
    if (s_axi_awvalid && r.awrdy) begin
      next_r.aw_have = 1'b1;
      next_r.awaddr = s_axi_awaddr;
      next_r.awrdy = 1'b0;
    end
    if (s_axi_wvalid && r.wrdy) begin
      next_r.w_have = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
      next_r.wrdy = 1'b0;
    end
    wr_go = r.aw_have && r.w_have && !r.bvalid;
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = DES_RESP_OKAY;
      unique case ({r.awaddr[7:2], 2'b00})
        DES_OFS_CTRL: begin
          // Host mode bit only honoured with permit on
          if (r.wstrb[0] && r.permit) begin
            next_r.host_dis = r.wdata[DES_CTRL_DIS_BIT]; // R11
            host_wr = 1'b1;
          end
        end
        DES_OFS_RAMP: begin
          if (r.wstrb[0]) next_r.ramp_ms[7:0] = r.wdata[7:0];
          if (r.wstrb[1]) next_r.ramp_ms[15:8] = r.wdata[15:8];
        end
        DES_OFS_STATE, DES_OFS_IND: begin
        end
        DES_OFS_ISTAT: begin
          if (r.wstrb[0]) next_r.ist = r.ist & ~r.wdata[3:0];
        end
        DES_OFS_IMASK: begin
          if (r.wstrb[0]) next_r.imask = r.wdata[3:0];
        end
        default: next_r.bresp = DES_RESP_SLVERR;
      endcase
    end

    // Enable sequencer
    ramp_end = DES_MS_W'(r.ramp_ms) + GATE_T;
    unique case (r.st)
      DES_ST_OFF: begin
        if (rise) begin
          next_r.pstage = 1'b1; // R03
          next_r.gate = !next_r.host_dis;
          next_r.en_ms = '0; // R17
          next_r.st = next_r.host_dis ? DES_ST_HOSTOFF : DES_ST_ON;
        end
      end
      DES_ST_ON: begin
        if (fall && s_jmp) begin
          // Coast: no ramp, power section off now
          next_r.pstage = 1'b0; // R10
          next_r.gate = 1'b0; // R10
          next_r.st = DES_ST_OFF;
          ev[DES_EV_GATE] = 1'b1;
        end else if (fall) begin
          next_r.ramp_req = 1'b1; // R07
          next_r.stop_ms = '0; // R17
          next_r.st = DES_ST_STOP_HW;
        end else if (host_wr && next_r.host_dis) begin
          next_r.ramp_req = 1'b1; // R13
          next_r.stop_ms = '0; // R17
          next_r.st = DES_ST_STOP_SW;
        end
      end
      DES_ST_STOP_HW: begin
        // Hardware backstop wins if the ramp never finishes
        stop_hit = r.stop_ms >= CUT_T; // R09
        gate_hit = (r.still_ms > GATE_T) || (r.stop_ms > ramp_end); // R08
        if (rise) begin
          next_r.ramp_req = 1'b0;
          next_r.en_ms = '0; // R17
          next_r.gate = !r.host_dis;
          next_r.st = r.host_dis ? DES_ST_HOSTOFF : DES_ST_ON;
        end else if (stop_hit || gate_hit) begin
          next_r.pstage = 1'b0; // R09
          next_r.gate = 1'b0; // R08
          next_r.ramp_req = 1'b0;
          next_r.st = DES_ST_OFF;
          ev[DES_EV_GATE] = 1'b1;
          ev[DES_EV_HWCUT] = stop_hit && !gate_hit;
        end
      end
      DES_ST_STOP_SW: begin
        if (fall) begin
          next_r.ramp_req = !s_jmp;
          next_r.pstage = !s_jmp;
          next_r.gate = !s_jmp;
          next_r.stop_ms = '0;
          next_r.st = s_jmp ? DES_ST_OFF : DES_ST_STOP_HW;
          ev[DES_EV_GATE] = s_jmp;
        end else if (host_wr && !next_r.host_dis) begin
          next_r.ramp_req = 1'b0; // R12
          next_r.st = DES_ST_ON;
        end else if (r.stop_ms > ramp_end) begin
          // No stage cutoff: hardware permit still stands
          next_r.gate = 1'b0; // R13 R14
          next_r.ramp_req = 1'b0;
          next_r.st = DES_ST_HOSTOFF;
          ev[DES_EV_GATE] = 1'b1;
        end
      end
      DES_ST_HOSTOFF: begin
        if (fall) begin
          next_r.pstage = 1'b0; // R02
          next_r.st = DES_ST_OFF;
        end else if (host_wr && !next_r.host_dis) begin
          next_r.gate = 1'b1; // R12
          next_r.st = DES_ST_ON;
        end
      end
      default: begin
        next_r.pstage = 1'b0;
        next_r.gate = 1'b0;
        next_r.ramp_req = 1'b0;
        next_r.st = DES_ST_OFF;
      end
    endcase

    // Strictly past N: a part-tick never counts, so delays run N to N+1 ms
    next_r.sw_ctl = next_r.pstage && r.permit && r.en_ms > SW_T; // R04
    next_r.cmd_ok = next_r.pstage && r.permit && r.en_ms > CMD_T; // R05

    // Indicator LEDs from the synchronised levels, the permit and the gate
    next_r.led = {next_r.gate, s_rdy, s_dout, s_rfe, r.permit, s_din,
                  s_lim}; // R15 R16

    // Sticky events: a set in the clear cycle survives
    ev[DES_EV_RISE] = rise;
    ev[DES_EV_FALL] = fall;
    next_r.ist = next_r.ist | ev;
    next_r.irq = |(next_r.ist & next_r.imask);

    // AXI read channel, one cycle to answer
    next_r.arrdy = !r.rvalid && !(s_axi_arvalid && r.arrdy);
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
      next_r.arrdy = 1'b1;
    end
    rd_go = s_axi_arvalid && r.arrdy;
    if (rd_go) begin
      ra = {s_axi_araddr[7:2], 2'b00};
      next_r.rvalid = 1'b1;
      next_r.rresp = DES_RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      unique case (ra)
        DES_OFS_CTRL: next_r.rdata[DES_CTRL_DIS_BIT] = r.host_dis;
        DES_OFS_RAMP: next_r.rdata[15:0] = r.ramp_ms;
        DES_OFS_STATE: begin
          next_r.rdata[DES_ST_ENA_BIT] = r.gate; // R06
          next_r.rdata[DES_ST_PSTAGE_BIT] = r.pstage;
          next_r.rdata[DES_ST_SWCTL_BIT] = r.sw_ctl;
          next_r.rdata[DES_ST_CMDOK_BIT] = r.cmd_ok;
          next_r.rdata[DES_ST_RAMP_BIT] = r.ramp_req;
          next_r.rdata[DES_ST_PERMIT_BIT] = r.permit;
          next_r.rdata[DES_ST_FSM_LSB +: 3] = r.st;
        end
        DES_OFS_IND: next_r.rdata[11:0] = r.led;
        DES_OFS_ISTAT: next_r.rdata[3:0] = r.ist;
        DES_OFS_IMASK: next_r.rdata[3:0] = r.imask;
        default: next_r.rresp = DES_RESP_SLVERR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= DES_ST_OFF;
      r.host_dis <= DES_RST_HOST_DIS;
      r.ramp_ms <= DES_RST_RAMP;
      r.imask <= DES_RST_IMASK;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops
  assign power_stage_en = r.pstage;
  assign gate_go = r.gate;
  assign sw_control = r.sw_ctl;
  assign cmd_accept = r.cmd_ok;
  assign ramp_to_zero = r.ramp_req;
  assign ind_led = r.led;
  assign irq = r.irq;
  assign s_axi_awready = r.awrdy;
  assign s_axi_wready = r.wrdy;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arrdy;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Helpers read only by assertions
  logic rd_state_q;
  logic [DES_MS_W-1:0] ramp_end_q;
  assign ramp_end_q = DES_MS_W'(r.ramp_ms) + GATE_T;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= 1'b0;
    end else begin
      rd_state_q <= s_axi_arvalid && r.arrdy
        && {s_axi_araddr[7:2], 2'b00} == DES_OFS_STATE;
    end
  end

  sequence seq_rise_off;
    !r.permit && r.st == DES_ST_OFF ##1 r.permit;
  endsequence
  sequence seq_fall_on;
    r.permit && r.st == DES_ST_ON ##1 !r.permit;
  endsequence

  AST_PERMIT_SET: assert property (s_pgt10 |=> r.permit) // R01
    else $error("permit not set above 10 V");
  AST_PERMIT_CLR: assert property (!s_pgt10 && s_plt4 |=> !r.permit) // R02
    else $error("permit not cleared below 4 V");
  AST_STAGE_NOW: assert property (seq_rise_off |=> r.pstage) // R03
    else $error("power stage not enabled at once");
  AST_SWCTL_LATE: assert property (r.sw_ctl |-> $past(r.en_ms) > SW_T) // R04
    else $error("software takeover too early");
  AST_CMD_LATE: assert property (r.cmd_ok |-> $past(r.en_ms) > CMD_T) // R05
    else $error("commands accepted too early");
  AST_ENA_FLAG: assert property (
    rd_state_q |-> s_axi_rdata[DES_ST_ENA_BIT] == $past(r.gate)) // R06
    else $error("enable flag wrong");
  AST_RAMP_OPEN: assert property ((!s_jmp ##0 seq_fall_on) |=>
    r.ramp_req && r.gate) // R07
    else $error("no ramp on open jumper");
  AST_GATE_EARLY: assert property (r.st == DES_ST_STOP_HW && r.permit == 0
    && !s_pgt10 && r.still_ms <= GATE_T && r.stop_ms <= ramp_end_q
    && r.stop_ms < CUT_T |=> r.gate) // R08
    else $error("gate dropped early");
  AST_CUTOFF: assert property (r.st == DES_ST_STOP_HW |->
    r.stop_ms <= CUT_T) // R09
    else $error("hardware cutoff late");
  AST_COAST: assert property ((s_jmp ##0 seq_fall_on) |=>
    !r.pstage && !r.gate) // R10
    else $error("no immediate disable");
  AST_HOST_NOPERMIT: assert property (!r.permit |=>
    $stable(r.host_dis)) // R11
    else $error("host bit changed without permit");
  AST_SW_NO_CUT: assert property (r.st == DES_ST_STOP_SW && r.permit
    ##1 r.permit |-> r.pstage) // R14
    else $error("host disable cut the stage");
  AST_LED_GATE: assert property (r.led[11] == r.gate) // R16
    else $error("gate indicator wrong");

endmodule : des_top

// ---- sim/des_host.sv ----
// Host model: an AXI4-Lite master that sends register traffic.
// Assumes one clock; every task starts after a rising edge.
`timescale 1ns/1ns

module des_host
  import des_pkg::*;
(
  // Clock and command gate
  input wire logic aclk,
  input wire logic cmd_accept,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Idle master at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
  endtask : wr

  // Read: data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : rd

  // Commands wait until the drive accepts them; no bound, bench cuts hangs
  task automatic cmd(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    while (!cmd_accept) @(posedge aclk);
    wr(a, d, r);
  endtask : cmd
endmodule : des_host

// ---- sim/drive_enable_sequencer_bench.sv ----
// Self-checking bench for the drive enable sequencer.
// Assumes a 10-cycle ms tick so the long delays stay short.
`timescale 1ns/1ns

module drive_enable_sequencer_bench;
  import des_pkg::*;
  localparam int TK = 10;
  // Pins and outputs
  logic aclk, aresetn, permit_gt10, permit_lt4, rotating_field_permit;
  logic ready_relay_out, axis_standstill, emergency_stop_jumper;
  logic [1:0] limit_gt10, din_gt10;
  logic [3:0] dout_pos;
  logic power_stage_en, gate_go, sw_control, cmd_accept, ramp_to_zero, irq;
  logic [11:0] ind_led;
  // Bus wires
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int fail_count, num_checks;

  des_top #(.TICK_CYCLES(TK)) dut (.aclk(aclk), .aresetn(aresetn),
    .permit_gt10(permit_gt10), .permit_lt4(permit_lt4),
    .limit_gt10(limit_gt10), .din_gt10(din_gt10),
    .rotating_field_permit(rotating_field_permit), .dout_pos(dout_pos),
    .ready_relay_out(ready_relay_out), .axis_standstill(axis_standstill),
    .emergency_stop_jumper(emergency_stop_jumper),
    .power_stage_en(power_stage_en), .gate_go(gate_go),
    .sw_control(sw_control), .cmd_accept(cmd_accept),
    .ramp_to_zero(ramp_to_zero), .ind_led(ind_led), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  des_host host (.aclk(aclk), .cmd_accept(cmd_accept), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %0t %s", $time, m);
      fail_count++;
    end
  endtask : chk

  task automatic permit(input logic on);
    @(posedge aclk);
    permit_gt10 <= on;
    permit_lt4 <= !on;
  endtask : permit

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk(power_stage_en | gate_go | irq, 0, "outputs after reset");
    host.rd(DES_OFS_RAMP, rv, rs);
    chk(rv, {16'h0000, DES_RST_RAMP}, "ramp reset value");
    host.rd(DES_OFS_IMASK, rv, rs);
    chk(rv, 0, "mask reset value");
    host.rd(8'h40, rv, rs);
    chk(rs, DES_RESP_SLVERR, "unmapped read");
    host.wr(8'h44, 32'h0000_0004, rs);
    chk(rs, DES_RESP_SLVERR, "unmapped write");
    $display("test reset finished");
  endtask : t_reset

  // Enable timing, hysteresis and the permit interrupt
  task automatic t_enable;
    permit(1'h1);
    cyc(5);
    chk(power_stage_en, 1, "stage not on at once");
    cyc(TK);
    chk(sw_control, 0, "software control early");
    cyc(3 * TK);
    chk({sw_control, cmd_accept}, 2'h2, "takeover timing");
    cyc(3 * TK);
    chk(cmd_accept, 1, "commands not accepted");
    host.rd(DES_OFS_STATE, rv, rs);
    chk(rv[DES_ST_ENA_BIT], 1, "enable flag");
    @(posedge aclk);
    permit_gt10 <= 1'h0;
    cyc(2 * TK);
    chk(power_stage_en, 1, "middle band dropped stage");
    permit_gt10 <= 1'h1;
    host.rd(DES_OFS_ISTAT, rv, rs);
    chk(rv[DES_EV_RISE], 1, "rise event");
    host.wr(DES_OFS_IMASK, 32'h0000_0001, rs);
    cyc(3);
    chk(irq, 1, "unmasked irq");
    host.wr(DES_OFS_ISTAT, 32'h0000_000f, rs);
    cyc(3);
    chk(irq, 0, "cleared irq");
    host.wr(DES_OFS_IMASK, 32'h0000_0000, rs);
    $display("test enable finished");
  endtask : t_enable

  // Permit removal; n is the expected drop delay in ms
  task automatic stop(input logic jmp, input logic still,
                      input logic [31:0] ramp, input int n);
    int early, late;
    // Drop lands 3 to 14 cycles past n ticks after the pin change
    early = jmp ? 0 : n * TK;
    late = jmp ? 5 : (n + 1) * TK + 5;
    host.wr(DES_OFS_RAMP, ramp, rs);
    @(posedge aclk);
    emergency_stop_jumper <= jmp;
    axis_standstill <= still;
    permit(1'h0);
    cyc(early);
    chk(power_stage_en, 1, "stage dropped early");
    if (!jmp && !still) chk(ramp_to_zero, 1, "no ramp");
    cyc(late - early);
    chk({power_stage_en, gate_go}, 0, "stage still on");
    permit(1'h1);
    emergency_stop_jumper <= 1'h0;
    axis_standstill <= 1'h0;
    cyc(7 * TK);
    $display("test stop %0d finished", n);
  endtask : stop

  // Host disable and re-enable, permit dependence
  task automatic t_host;
    host.wr(DES_OFS_RAMP, 32'h0000_0014, rs);
    host.cmd(DES_OFS_CTRL, 32'h0000_0004, rs);
    cyc(2 * TK);
    chk(ramp_to_zero, 1, "host ramp");
    cyc(68 * TK - 2);
    chk(gate_go, 1, "gate dropped early");
    cyc(TK + 10);
    chk(gate_go, 0, "gate still on");
    cyc(1530 * TK);
    chk(power_stage_en, 1, "hardware cut on host disable");
    host.cmd(DES_OFS_CTRL, 32'h0000_0000, rs);
    cyc(3);
    chk(gate_go, 1, "host enable delayed");
    emergency_stop_jumper <= 1'h1;
    permit(1'h0);
    cyc(8);
    host.wr(DES_OFS_CTRL, 32'h0000_0004, rs);
    host.rd(DES_OFS_CTRL, rv, rs);
    chk(rv[DES_CTRL_DIS_BIT], 0, "command without permit");
    permit(1'h1);
    emergency_stop_jumper <= 1'h0;
    cyc(7 * TK);
    chk(gate_go, 1, "gate after permit");
    $display("test host finished");
  endtask : t_host

  // One indicator at a time; permit and gate bits stay lit
  task automatic t_ind;
    logic [11:0] p;
    for (int i = 0; i < 11; i++) begin
      if (i == 4) continue;
      p = 12'h001 << i;
      @(posedge aclk);
      limit_gt10 <= p[1:0];
      din_gt10 <= p[3:2];
      rotating_field_permit <= p[5];
      dout_pos <= p[9:6];
      ready_relay_out <= p[10];
      cyc(5);
      chk(ind_led, p | 12'h810, "indicator pin");
      host.rd(DES_OFS_IND, rv, rs);
      chk(rv, {20'h0_0000, p | 12'h810}, "indicator word");
    end
    $display("test indicators finished");
  endtask : t_ind

  ////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    aresetn = 1'h0;
    {permit_gt10, rotating_field_permit, ready_relay_out} = '0;
    {axis_standstill, emergency_stop_jumper} = '0;
    permit_lt4 = 1'h1;
    {limit_gt10, din_gt10, dout_pos} = '0;
    fail_count = 0;
    num_checks = 0;
    cyc(3);
    aresetn <= 1'h1;
    cyc(2);
    t_reset();
    t_enable();
    t_ind();
    stop(1'h0, 1'h0, 32'h0000_0003, 53);
    stop(1'h0, 1'h1, 32'h0000_0014, 50);
    // Cutoff is a no-later-than bound, so it may land in the last ms
    stop(1'h0, 1'h0, 32'h0000_07d0, 1499);
    stop(1'h1, 1'h0, 32'h0000_0003, 0);
    t_host();
    end_of_test();
  end

  // Run needs about 33000 cycles
  initial begin
    cyc(90000);
    fail_count++;
    end_of_test();
  end
endmodule : drive_enable_sequencer_bench
